// file: hw/rsp_pkg.sv
// package: constants, register map and carriers for the stream read engine
package rsp_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] ADR_CMD      = 8'h00;  // command code (write)
  localparam logic [7:0] ADR_FEAT     = 8'h04;  // feature cur[7:0] prev[15:8]
  localparam logic [7:0] ADR_SCNT     = 8'h08;  // sector count [15:0]
  localparam logic [7:0] ADR_LBA_LO   = 8'h0c;  // lba [31:0]
  localparam logic [7:0] ADR_LBA_HI   = 8'h10;  // lba [47:32]
  localparam logic [7:0] ADR_CTRL     = 8'h14;  // bit0 hob select
  localparam logic [7:0] ADR_STATUS   = 8'h18;  // device_status
  localparam logic [7:0] ADR_ERROR    = 8'h1c;  // error_flags
  localparam logic [7:0] ADR_ELOG     = 8'h20;  // error log
  localparam logic [7:0] ADR_RET_LBA  = 8'h24;  // failing lba, hob selected
  localparam logic [7:0] ADR_DATA     = 8'h28;  // sector word read port
  localparam logic [7:0] ADR_IRQ_ST   = 8'h2c;  // sticky events (ro)
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h30;  // write one to clear
  localparam logic [7:0] ADR_IRQ_EN   = 8'h34;  // event enables
  localparam logic [7:0] ADR_TMUL     = 8'h38;  // time unit (identify 99:98)

  localparam logic [7:0] CMD_READ_STREAM_PIO = 8'h2b;

  // feature fields
  localparam int FEAT_URGENT   = 7;
  localparam int FEAT_RCONT    = 6;
  localparam int FEAT_SID_MSB  = 2;

  // error_flags and error log bit positions (CCTO is set only in the error log)
  localparam int ERR_CRC  = 7;
  localparam int ERR_UNC  = 6;
  localparam int ERR_IDNF = 4;
  localparam int ERR_ABRT = 2;
  localparam int ERR_CCTO = 0;

  // device_status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_SE  = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;

  // interrupt events
  localparam int IRQ_DONE  = 0;
  localparam int IRQ_SERR  = 1;
  localparam int IRQ_CCTO  = 2;
  localparam int IRQ_W     = 3;

  localparam int CLK_MHZ      = 20;  // 50 ns period
  localparam int US_CYCLES    = CLK_MHZ;  // cycles per microsecond
  localparam logic [16:0] SECTORS_MAX = 17'h10000;  // count 0 means this
  localparam logic [7:0]  WORDS_PER_SECTOR = 8'hff;  // 256 words, minus one

  // sector media result from the read channel
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
    logic        crc_err;
    logic        unc_err;
    logic        idnf_err;
    logic        abrt_err;
  } rsp_media_s;

  typedef enum logic [1:0] {
    RSP_IDLE = 2'b00,
    RSP_XFER = 2'b01,
    RSP_DONE = 2'b10
  } rsp_state_e;
endpackage

// file: hw/rsp_read_stream.sv
// streaming read command engine with programmed data transfer
//
// Added by the designer: the address map and the Wishbone slave port.
module rsp_read_stream (
  // clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // media read channel
  input  wire rsp_pkg::rsp_media_s media_i,
  output logic                   media_req_o,
  output logic      [47:0]       media_lba_o,
  output logic      [2:0]        stream_id_o,
  output logic                   urgent_o,
  // interrupt
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // state
  localparam int IRQ_W_L = rsp_pkg::IRQ_W;  // event count, sizes irq regs
  rsp_pkg::rsp_state_e state;      // command phase
  logic [15:0] feat;               // feature cur/prev
  logic [15:0] scnt;               // sector count
  logic [47:0] lba;                // start lba
  logic [15:0] tmul;               // identify words 99:98 value
  logic        hob;                // high order byte select
  logic [16:0] left;               // sectors still to move
  logic [7:0]  wcnt;               // word within sector
  logic [47:0] cur_lba;            // lba of sector in flight
  logic [47:0] bad_lba;            // first failing sector
  logic        bad_seen;           // a failing sector already captured
  logic [7:0]  err_flags;          // error_flags register
  logic [7:0]  elog;               // error log bits
  logic        se_bit;             // stream error status
  logic        err_bit;            // error status
  logic        drq;                // word waiting for host
  logic [15:0] dword;              // held data word
  logic        rcont;              // continuous mode latched
  logic [31:0] tlim;               // remaining time in microseconds
  logic        tlim_on;            // time limit active
  logic [5:0]  us_div;             // microsecond prescaler
  logic [IRQ_W_L-1:0] irq_st;      // sticky events
  logic [IRQ_W_L-1:0] irq_en;      // event enables

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire bus_req  = cyc_i & stb_i & ~ack_o;
  wire wr       = bus_req & we_i & sel_i[0];
  wire rd       = bus_req & ~we_i;

  // word selects a register address
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  wire start    = wr & hit(adr_i, rsp_pkg::ADR_CMD) & (state != rsp_pkg::RSP_XFER)
                  & (dat_i[7:0] == rsp_pkg::CMD_READ_STREAM_PIO);
  wire data_rd  = rd & hit(adr_i, rsp_pkg::ADR_DATA) & drq;
  wire [16:0] start_cnt = (scnt == 16'h0000) ? rsp_pkg::SECTORS_MAX
                          : {1'b0, scnt};
  // time limit in microseconds: prev feature times unit
  wire [31:0] lim_cyc = 32'(feat[15:8]) * 32'(tmul);
  wire        lim_use = (lim_cyc != 32'h0);
  wire        expired = tlim_on & (tlim == 32'h0);
  wire        tick_us = (us_div == 6'(rsp_pkg::US_CYCLES - 1));
  wire        any_err = media_i.crc_err | media_i.unc_err
                        | media_i.idnf_err | media_i.abrt_err;
  wire        take    = (state == rsp_pkg::RSP_XFER) & media_i.valid & ~drq;
  wire        last_w  = (wcnt == rsp_pkg::WORDS_PER_SECTOR);
  wire        abort_n = take & any_err & ~rcont;
  wire        fin_ok  = data_rd & last_w & (left == 17'h1);
  wire [7:0]  err_new = {media_i.crc_err, media_i.unc_err, 1'b0,
                         media_i.idnf_err, 1'b0, media_i.abrt_err,
                         2'b00};
  wire [7:0]  status  = {(state == rsp_pkg::RSP_XFER) & ~drq, 1'b1, se_bit,
                         1'b0, drq, 1'b0, 1'b0, err_bit};
  wire [47:0] ret_lba = bad_seen ? bad_lba : cur_lba;
  wire [IRQ_W_L-1:0] ev = {expired & rcont, fin_ok & se_bit,
                           fin_ok | abort_n | (expired & rcont)};
  wire [IRQ_W_L-1:0] clr = (wr & hit(adr_i, rsp_pkg::ADR_IRQ_CLR))
                           ? dat_i[IRQ_W_L-1:0] : '0;

  // read mux
  logic [31:0] next_dat;
  always_comb begin
    case (adr_i)
      rsp_pkg::ADR_FEAT:    next_dat = {16'h0, feat};
      rsp_pkg::ADR_SCNT:    next_dat = {16'h0, scnt};
      rsp_pkg::ADR_LBA_LO:  next_dat = lba[31:0];
      rsp_pkg::ADR_LBA_HI:  next_dat = {16'h0, lba[47:32]};
      rsp_pkg::ADR_CTRL:    next_dat = {31'h0, hob};
      rsp_pkg::ADR_STATUS:  next_dat = {24'h0, status};
      rsp_pkg::ADR_ERROR:   next_dat = {24'h0, err_flags};
      rsp_pkg::ADR_ELOG:    next_dat = {24'h0, elog};
      // hob picks upper or lower three bytes
      rsp_pkg::ADR_RET_LBA: next_dat = hob ? {8'h0, ret_lba[47:24]}
                                           : {8'h0, ret_lba[23:0]};
      rsp_pkg::ADR_DATA:    next_dat = {16'h0, dword};
      rsp_pkg::ADR_IRQ_ST:  next_dat = {29'h0, irq_st};
      rsp_pkg::ADR_IRQ_EN:  next_dat = {29'h0, irq_en};
      rsp_pkg::ADR_TMUL:    next_dat = {16'h0, tmul};
      default:              next_dat = 32'h0;  // unmapped reads zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // bus ack and read data, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else if (ce_i) begin
      ack_o <= bus_req;
      dat_o <= bus_req ? next_dat : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parameter registers written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feat <= 16'h0;
      scnt <= 16'h0;
      lba  <= 48'h0;
      hob  <= 1'b0;
      tmul <= 16'h0;
      irq_en <= '0;
    end else if (ce_i && wr) begin
      case (adr_i)
        rsp_pkg::ADR_FEAT:   feat <= dat_i[15:0];
        rsp_pkg::ADR_SCNT:   scnt <= dat_i[15:0];
        rsp_pkg::ADR_LBA_LO: lba[31:0] <= dat_i;
        rsp_pkg::ADR_LBA_HI: lba[47:32] <= dat_i[15:0];
        rsp_pkg::ADR_CTRL:   hob <= dat_i[0];
        rsp_pkg::ADR_TMUL:   tmul <= dat_i[15:0];
        rsp_pkg::ADR_IRQ_EN: irq_en <= dat_i[IRQ_W_L-1:0];
        default: ;  // other writes store nothing here
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= rsp_pkg::RSP_IDLE;
      left <= 17'h0;
      wcnt <= 8'h0;
      cur_lba <= 48'h0;
      drq <= 1'b0;
      dword <= 16'h0;
      rcont <= 1'b0;
    end else if (ce_i) begin
      case (state)
        rsp_pkg::RSP_IDLE, rsp_pkg::RSP_DONE: begin
          if (start) begin
            state <= rsp_pkg::RSP_XFER;
            left <= start_cnt;
            wcnt <= 8'h0;
            cur_lba <= lba;
            drq <= 1'b0;
            rcont <= feat[rsp_pkg::FEAT_RCONT];
          end
        end
        rsp_pkg::RSP_XFER: begin
          if ((expired && rcont) || abort_n) begin
            state <= rsp_pkg::RSP_DONE;
            drq <= 1'b0;
          end else if (take) begin
            // continuous mode keeps bad words flowing
            drq <= 1'b1;
            dword <= media_i.data;
          end else if (data_rd) begin
            drq <= 1'b0;
            wcnt <= last_w ? 8'h0 : wcnt + 8'h1;
            if (last_w) begin
              cur_lba <= cur_lba + 48'h1;
              left <= left - 17'h1;
              if (left == 17'h1)
                state <= rsp_pkg::RSP_DONE;
            end
          end
        end
        default: state <= rsp_pkg::RSP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error reporting: error bit, stream error, error log, failing lba
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_flags <= 8'h0;
      elog <= 8'h0;
      se_bit <= 1'b0;
      err_bit <= 1'b0;
      bad_lba <= 48'h0;
      bad_seen <= 1'b0;
    end else if (ce_i) begin
      if (start) begin
        err_flags <= 8'h0;
        elog <= 8'h0;
        se_bit <= 1'b0;
        err_bit <= 1'b0;
        bad_seen <= 1'b0;
      end else if (state == rsp_pkg::RSP_XFER) begin
        if (take && any_err) begin
          if (!bad_seen) begin
            bad_lba <= cur_lba;
            bad_seen <= 1'b1;
          end
          if (rcont) begin
            se_bit <= 1'b1;
            elog <= elog | err_new;
          end else begin
            err_bit <= 1'b1;
            err_flags <= err_new;
          end
        end
        if (expired && rcont) begin
          se_bit <= 1'b1;
          elog[rsp_pkg::ERR_CCTO] <= 1'b1;
          // error bit stays clear in continuous mode
          err_bit <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion time limit, counted in microsecond ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tlim <= 32'h0;
      tlim_on <= 1'b0;
      us_div <= 6'h0;
    end else if (ce_i) begin
      if (start) begin
        tlim <= lim_cyc;
        tlim_on <= lim_use;  // zero limit means ignored
        us_div <= 6'h0;
      end else if (state != rsp_pkg::RSP_XFER) begin
        tlim_on <= 1'b0;
      end else if (tlim_on && tlim != 32'h0) begin
        us_div <= tick_us ? 6'h0 : us_div + 6'h1;
        if (tick_us)
          tlim <= tlim - 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st <= '0;
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_st <= (irq_st & ~clr) | ev;
      irq_o <= |(((irq_st & ~clr) | ev) & irq_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // media request outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      media_req_o <= 1'b0;
      media_lba_o <= 48'h0;
      stream_id_o <= 3'h0;
      urgent_o <= 1'b0;
    end else if (ce_i) begin
      media_req_o <= (state == rsp_pkg::RSP_XFER) & ~drq & ~take;
      media_lba_o <= cur_lba;
      stream_id_o <= feat[rsp_pkg::FEAT_SID_MSB:0];
      urgent_o <= feat[rsp_pkg::FEAT_URGENT];
    end
  end

endmodule

// file: sim/rsp_read_stream_monitor.sv
// checker: bus handshake, reset and status properties at the engine's ports
module rsp_read_stream_monitor (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // media and interrupt
  input wire logic        media_req_o,
  input wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] feat_q;  // last feature byte written
  logic       rc_q;    // continuous flag of the running command
  logic       wr;      // acked write
  logic       rd_st;   // acked status read
  logic       rd_er;   // acked error read
  assign wr    = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  assign rd_st = cyc_i && stb_i && !we_i && ack_o
                 && adr_i == rsp_pkg::ADR_STATUS;
  assign rd_er = cyc_i && stb_i && !we_i && ack_o
                 && adr_i == rsp_pkg::ADR_ERROR;
  // flag is latched at the command, not the feature write, so a stale
  // error from an older command is never judged against a new flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      feat_q <= 8'h00;
      rc_q   <= 1'h0;
    end else if (wr) begin
      if (adr_i == rsp_pkg::ADR_FEAT) feat_q <= dat_i[7:0];
      if (adr_i == rsp_pkg::ADR_CMD
          && dat_i[7:0] == rsp_pkg::CMD_READ_STREAM_PIO)
        rc_q <= feat_q[rsp_pkg::FEAT_RCONT];
    end
  end
  property p_ack_follow;
    cyc_i && stb_i && !ack_o && ce_i |=> ack_o;
  endproperty
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  property p_ack_cause;
    $rose(ack_o) |-> $past(cyc_i && stb_i);
  endproperty
  property p_reset_quiet;
    disable iff (1'h0) rst_i |=> !ack_o && !irq_o && !media_req_o;
  endproperty
  property p_rc_no_err;
    rd_st && rc_q |-> !dat_o[rsp_pkg::ST_ERR];
  endproperty
  property p_st_fixed;
    rd_st |-> dat_o[rsp_pkg::ST_RDY] && !dat_o[4] && !dat_o[2];
  endproperty
  property p_er_fixed;
    rd_er |-> !dat_o[5] && !dat_o[3] && !dat_o[1];
  endproperty
  property p_unmapped;
    cyc_i && !we_i && ack_o && adr_i[7:2] > 6'h0e |-> dat_o == 32'h0;
  endproperty
  a_ack_follow:  assert property (p_ack_follow) else $error("no ack");
  a_ack_pulse:   assert property (p_ack_pulse) else $error("long ack");
  a_ack_cause:   assert property (p_ack_cause) else $error("stray ack");
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset");
  a_rc_no_err:   assert property (p_rc_no_err) else $error("err set");
  a_st_fixed:    assert property (p_st_fixed) else $error("status");
  a_er_fixed:    assert property (p_er_fixed) else $error("error");
  a_unmapped:    assert property (p_unmapped) else $error("hole");
  c_irq:   cover property ($rose(irq_o));
  c_se:    cover property (rd_st && dat_o[rsp_pkg::ST_SE]);
  c_drq:   cover property (rd_st && dat_o[rsp_pkg::ST_DRQ]);
endmodule
bind rsp_read_stream rsp_read_stream_monitor u_mon (.*);

// file: sim/rsp_media_model.sv
// media source model: numbered words on request, one fault on demand
module rsp_media_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clr_i,      // restart word numbering
  input  wire logic        slow_i,     // answer every other cycle
  input  wire logic [15:0] err_idx_i,  // word that carries the fault
  input  wire logic [3:0]  err_kind_i, // crc, unc, idnf, abrt
  input  wire logic        req_i,      // engine wants a word
  output rsp_pkg::rsp_media_s media_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] idx;   // words handed out
  logic [15:0] last;  // last word, inverted while idle
  logic        ph;    // slow phase
  logic        give;  // word handed out this cycle
  logic [3:0]  bad;   // fault flags of this word
  assign give = req_i && !(slow_i && ph);
  assign bad  = (give && idx == err_idx_i) ? err_kind_i : 4'h0;
  // idle data is the inverse of the last word so a stale bus never matches
  assign media_o = {give, give ? idx ^ 16'ha5c3 : ~last, bad};
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      idx <= 16'h0;
      ph  <= 1'h0;
    end else begin
      ph <= ~ph;
      if (give) idx <= idx + 16'h1;
      if (give) last <= idx ^ 16'ha5c3;
    end
  end
endmodule

// file: sim/rsp_read_stream_tb.sv
// testbench: table of read commands, then timeout, register and reset cases
module rsp_read_stream_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic rc; logic urg; logic [2:0] sid; logic [15:0] cnt; logic [15:0] ew;
    logic [3:0] ek; logic slow; logic full; logic [7:0] st; logic [7:0] er;
    logic [7:0] lg;
  } rsp_row_s;
  logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, clr, slow;
  logic        media_req_o, urgent_o, irq_o;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i, ek;
  logic [31:0] dat_i, dat_o, q, s;
  logic [15:0] ew;
  logic [2:0]  stream_id_o;
  logic [47:0] media_lba_o, fl;
  rsp_pkg::rsp_media_s media_i;
  rsp_row_s    rows [6];
  rsp_row_s    g;
  int          fail_count = 0, num_checks = 0, cyc_n = 0, nw;
  rsp_read_stream dut (.*);
  rsp_media_model u_media (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
    .slow_i(slow), .err_idx_i(ew), .err_kind_i(ek), .req_i(media_req_o),
    .media_o(media_i));
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  // watchdog: the whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 80000) begin
      fail_count++;
      $display("Error %0t run timed out", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, msk);
    num_checks++;
    if ((got & msk) !== (exp & msk)) begin
      fail_count++;
      $display("Error %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= a; dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    r = dat_o;
    cyc_i <= 1'h0; stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // set up and issue one command, then serve data until the interrupt
  task automatic run(input rsp_row_s r, input logic [7:0] p);
    ew <= r.ew; ek <= r.ek; slow <= r.slow; clr <= 1'h1;
    @(posedge clk_i);
    clr <= 1'h0;
    wb(1'h1, rsp_pkg::ADR_FEAT, {16'h0, p, r.urg, r.rc, 3'h0, r.sid}, q);
    wb(1'h1, rsp_pkg::ADR_SCNT, {16'h0, r.cnt}, q);
    wb(1'h1, rsp_pkg::ADR_LBA_LO, 32'h89abcdef, q);
    wb(1'h1, rsp_pkg::ADR_LBA_HI, 32'h0123, q);
    wb(1'h1, rsp_pkg::ADR_CMD, 32'h2b, q);
    chk(stream_id_o, r.sid, 32'h7);
    chk(urgent_o, r.urg, 32'h1);
    nw = 0;
    do begin
      wb(1'h0, rsp_pkg::ADR_STATUS, 32'h0, s);
      if (s[rsp_pkg::ST_DRQ]) begin
        wb(1'h0, rsp_pkg::ADR_DATA, 32'h0, q);
        if (r.full) chk(q, nw[15:0] ^ 16'ha5c3, 32'hffff);
        nw++;
      end
    end while (irq_o !== 1'h1);
  endtask
  initial begin
    rst_i = 1'h1; ce_i = 1'h1; sel_i = 4'hf; cyc_i = 1'h0; stb_i = 1'h0;
    we_i = 1'h0; adr_i = 8'h0; dat_i = 32'h0; clr = 1'h0; slow = 1'h0;
    ew = 16'hffff; ek = 4'h0;
    rows[0] = {5'h0d, 16'h1, 16'hffff, 4'h0, 2'h1, 8'h40, 8'h0, 8'h0};
    rows[1] = {5'h12, 16'h2, 16'h012c, 4'h8, 2'h3, 8'h60, 8'h0, 8'h80};
    rows[2] = {5'h11, 16'h1, 16'h0007, 4'h4, 2'h1, 8'h60, 8'h0, 8'h40};
    rows[3] = {5'h1b, 16'h1, 16'h00ff, 4'h2, 2'h1, 8'h60, 8'h0, 8'h10};
    rows[4] = {5'h17, 16'h1, 16'h0000, 4'h1, 2'h3, 8'h60, 8'h0, 8'h04};
    rows[5] = {5'h00, 16'h1, 16'h000a, 4'h4, 2'h0, 8'h41, 8'h40, 8'h0};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h1, rsp_pkg::ADR_TMUL, 32'h1, q);
    wb(1'h1, rsp_pkg::ADR_IRQ_EN, 32'h7, q);
    foreach (rows[i]) begin
      run(rows[i], 8'h0);
      wb(1'h0, rsp_pkg::ADR_STATUS, 32'h0, q);
      chk(q, rows[i].st, 32'hfd);
      wb(1'h0, rsp_pkg::ADR_ERROR, 32'h0, q);
      chk(q, rows[i].er, 32'hff);
      if (rows[i].full) begin
        wb(1'h0, rsp_pkg::ADR_ELOG, 32'h0, q);
        chk(q, rows[i].lg, 32'hff);
        chk(nw, 256 * rows[i].cnt, 32'hffffffff);
        chk(media_lba_o[31:0], 32'h89abcdef + rows[i].cnt, 32'hffffffff);
      end
      if (rows[i].ew != 16'hffff) begin
        fl = 48'h012389abcdef + rows[i].ew[15:8];
        wb(1'h0, rsp_pkg::ADR_RET_LBA, 32'h0, q);
        chk(q, fl[23:0], 32'hffffff);
        wb(1'h1, rsp_pkg::ADR_CTRL, 32'h1, q);
        wb(1'h0, rsp_pkg::ADR_RET_LBA, 32'h0, q);
        chk(q, fl[47:24], 32'hffffff);
        wb(1'h1, rsp_pkg::ADR_CTRL, 32'h0, q);
      end
      wb(1'h1, rsp_pkg::ADR_IRQ_CLR, 32'h7, q);
      chk(irq_o, 32'h0, 32'h1);
      $display("row %0d done", i);
    end
    g = {5'h10, 16'h0, 16'hffff, 4'h0, 2'h1, 24'h0};
    run(g, 8'hc8);
    chk(nw > 256, 32'h1, 32'h1);
    wb(1'h0, rsp_pkg::ADR_STATUS, 32'h0, q);
    chk(q, 32'h60, 32'hf5);
    wb(1'h0, rsp_pkg::ADR_ELOG, 32'h0, q);
    chk(q, 32'h01, 32'h01);
    wb(1'h0, rsp_pkg::ADR_IRQ_ST, 32'h0, q);
    chk(q, 32'h4, 32'h4);
    wb(1'h1, rsp_pkg::ADR_IRQ_EN, 32'h0, q);
    chk(irq_o, 32'h0, 32'h1);
    wb(1'h1, rsp_pkg::ADR_IRQ_EN, 32'h7, q);
    chk(irq_o, 32'h1, 32'h1);
    wb(1'h1, rsp_pkg::ADR_IRQ_CLR, 32'h7, q);
    chk(irq_o, 32'h0, 32'h1);
    $display("timeout and irq case done");
    // stream error of the timed-out command stays until the next read stream command
    wb(1'h1, rsp_pkg::ADR_STATUS, 32'hff, q);
    wb(1'h0, rsp_pkg::ADR_STATUS, 32'h0, q);
    chk(q, 32'h60, 32'hff);
    wb(1'h0, 8'h3c, 32'h0, q);
    chk(q, 32'h0, 32'hffffffff);
    wb(1'h1, rsp_pkg::ADR_CMD, 32'h20, q);
    wb(1'h0, rsp_pkg::ADR_STATUS, 32'h0, q);
    chk(q, 32'h60, 32'hff);
    chk(media_req_o, 32'h0, 32'h1);
    $display("register case done");
    // a frozen engine must not answer a waiting bus request
    ce_i <= 1'h0;
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= 1'h0;
    adr_i <= rsp_pkg::ADR_STATUS;
    repeat (3) @(posedge clk_i);
    chk(ack_o, 32'h0, 32'h1);
    ce_i <= 1'h1;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
    $display("clock enable case done");
    wb(1'h1, rsp_pkg::ADR_CMD, 32'h2b, q);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk(media_req_o, 32'h0, 32'h1);
    wb(1'h0, rsp_pkg::ADR_STATUS, 32'h0, q);
    chk(q, 32'h40, 32'hff);
    $display("reset case done");
    tally_and_finish();
  end
endmodule
